// >>> hw/ectm_map.svh
`ifndef ECTM_MAP_SVH
`define ECTM_MAP_SVH
// Register addresses
`define ECTM_A_CTL0 4'h0
`define ECTM_A_CTL1 4'h1
`define ECTM_A_CNTH 4'h2
`define ECTM_A_CNTL 4'h3
`define ECTM_A_RLDH 4'h4
`define ECTM_A_RLDL 4'h5
`define ECTM_A_CAPH 4'h6
`define ECTM_A_CAPL 4'h7
`define ECTM_A_STAT 4'h8
`define ECTM_A_MASK 4'h9
// Control 0 fields: enable, polarity, mode[1:0], prescale[2:0]
`define ECTM_B_EN 7
`define ECTM_B_POL 6
`define ECTM_B_MODE_HI 5
`define ECTM_B_MODE_LO 4
`define ECTM_B_PRE_HI 2
`define ECTM_B_PRE_LO 0
// Control 1 fields: output enable, interrupt source select
`define ECTM_B_OE 7
`define ECTM_B_ISRC_HI 1
`define ECTM_B_ISRC_LO 0
// Status bits
`define ECTM_B_ST_RLD 0
`define ECTM_B_ST_CAP 1
// Reset and restart values
`define ECTM_RESTART 16'h0001
`define ECTM_CNT_RST 16'h0001
`define ECTM_RLD_RST 16'hFFFF
`define ECTM_CTL_RST 8'h00
`define ECTM_ZERO8 8'h00
`endif

// >>> hw/ectm_pkg.sv
package ectm_pkg;
   typedef enum logic [1:0] {
      ECTM_MODE_EVENT = 2'h0,
      ECTM_MODE_COMP = 2'h1,
      ECTM_MODE_CAPCMP = 2'h2,
      ECTM_MODE_RSVD = 2'h3
   } ectm_mode_t;
   typedef enum logic [1:0] {
      ECTM_ISRC_BOTH = 2'h0,
      ECTM_ISRC_CAP = 2'h1,
      ECTM_ISRC_RLD = 2'h2,
      ECTM_ISRC_BOTH2 = 2'h3
   } ectm_isrc_t;
   typedef enum logic [2:0] {
      ECTM_ST_IDLE = 3'h1,
      ECTM_ST_ARM = 3'h2,
      ECTM_ST_RUN = 3'h4
   } ectm_state_t;
endpackage

// >>> hw/ectm_edge.sv
`timescale 1ns/1ps
`include "ectm_map.svh"
// Two-stage synchroniser and single edge detector
module ectm_edge import ectm_pkg::*; (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic async_in,
   input wire logic falling_sel,
   output logic edge_pulse
);
   logic [2:0] sync_q;
   logic [2:0] sync_d;
   logic edge_d;
   logic edge_q;

   // Shift chain; stage 2 holds the prior synchronised sample
   always_comb begin
      sync_d = {sync_q[1:0], async_in};
      edge_d = falling_sel ? (sync_q[2] & ~sync_q[1]) : (~sync_q[2] & sync_q[1]);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sync_q <= 3'h0;
         edge_q <= 1'b0;
      end else begin
         sync_q <= sync_d;
         edge_q <= edge_d;
      end
   end

   assign edge_pulse = edge_q;
endmodule

// >>> hw/ectm_top.sv
`timescale 1ns/1ps
`include "ectm_map.svh"
module ectm_top import ectm_pkg::*; (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic timer_in,
   input wire logic comp_in,
   output logic timer_out,
   output logic timer_out_n,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////////
   // State and next values
   logic [7:0] ctl0_q, ctl0_d;
   logic [7:0] ctl1_q, ctl1_d;
   logic [15:0] cnt_q, cnt_d;
   logic [15:0] rld_q, rld_d;
   logic [15:0] cap_q, cap_d;
   logic [1:0] stat_q, stat_d;
   logic [1:0] mask_q, mask_d;
   logic [7:0] pre_q, pre_d;
   logic tout_q, tout_d;
   logic toutn_q, toutn_d;
   logic irq_q, irq_d;
   logic [7:0] rdata_q, rdata_d;
   ectm_state_t st_q, st_d;
   logic pin_edge;
   logic cmp_edge;
   logic src_edge;
   logic tick;
   logic pre_end;
   logic reload;
   logic capture;
   logic rld_ev;
   logic cap_ev;
   ectm_mode_t mode;
   ectm_isrc_t isrc;
   logic en;
   logic pol;

   ////////////////////////////////////////////////////////////////////////////////
   // Prescale length of 1 to 128 clocks from the three-bit code
   function automatic logic [7:0] pre_last(input logic [2:0] code);
      pre_last = 8'(({7'h00, 1'b1} << code) - 8'h01);
   endfunction

   // Register address match
   function automatic logic hit(input logic [3:0] a, input logic [3:0] ref_a);
      hit = (a == ref_a);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Edge detectors for the pin and the comparator
   ectm_edge u_pin_edge (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .async_in(timer_in),
      .falling_sel(pol),
      .edge_pulse(pin_edge)
   );

   ectm_edge u_cmp_edge (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .async_in(comp_in),
      .falling_sel(pol),
      .edge_pulse(cmp_edge)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Decoded control fields
   assign en = ctl0_q[`ECTM_B_EN];
   assign pol = ctl0_q[`ECTM_B_POL];
   assign mode = ectm_mode_t'(ctl0_q[`ECTM_B_MODE_HI:`ECTM_B_MODE_LO]);
   assign isrc = ectm_isrc_t'(ctl1_q[`ECTM_B_ISRC_HI:`ECTM_B_ISRC_LO]);
   assign src_edge = (mode == ECTM_MODE_COMP) ? cmp_edge : pin_edge;
   // Last clock of the prescale period
   assign pre_end = (pre_q == pre_last(ctl0_q[`ECTM_B_PRE_HI:`ECTM_B_PRE_LO]));

   // Count source: raw edge in counting modes, prescale tick in capture/compare
   always_comb begin
      tick = 1'b0;
      capture = 1'b0;
      case (mode)
         ECTM_MODE_EVENT: tick = src_edge;
         ECTM_MODE_COMP: tick = src_edge;
         ECTM_MODE_CAPCMP: begin
            tick = (st_q == ECTM_ST_RUN) && pre_end;
            capture = (st_q == ECTM_ST_RUN) && pin_edge;
         end
         default: tick = 1'b0;
      endcase
   end

   assign reload = tick && (cnt_q == rld_q);
   assign rld_ev = en && reload;
   assign cap_ev = en && capture;

   ////////////////////////////////////////////////////////////////////////////////
   // Run state: capture/compare waits for first input edge
   always_comb begin
      st_d = st_q;
      case (st_q)
         ECTM_ST_IDLE: begin
            if (en) begin
               st_d = (mode == ECTM_MODE_CAPCMP) ? ECTM_ST_ARM : ECTM_ST_RUN;
            end
         end
         ECTM_ST_ARM: begin
            if (!en) begin
               st_d = ECTM_ST_IDLE;
            end else if (pin_edge) begin
               st_d = ECTM_ST_RUN;
            end
         end
         ECTM_ST_RUN: begin
            if (!en) begin
               st_d = ECTM_ST_IDLE;
            end
         end
         default: st_d = ECTM_ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Counter, prescaler, capture and timer output
   always_comb begin
      cnt_d = cnt_q;
      pre_d = pre_q;
      cap_d = cap_q;
      tout_d = tout_q;
      if (!en) begin
         pre_d = `ECTM_ZERO8;
         tout_d = pol;
      end else begin
         if (mode == ECTM_MODE_CAPCMP && st_q == ECTM_ST_RUN) begin
            pre_d = pre_end ? `ECTM_ZERO8 : 8'(pre_q + 8'h01);
         end
         if (reload) begin
            cnt_d = `ECTM_RESTART;
            if (ctl1_q[`ECTM_B_OE]) begin
               tout_d = ~tout_q;
            end
         end else if (tick) begin
            cnt_d = 16'(cnt_q + 16'h0001);
         end
         if (capture) begin
            cap_d = cnt_q;
         end
      end
      // Software writes to the count bytes land last
      if (reg_wr && hit(reg_addr, `ECTM_A_CNTH)) begin
         cnt_d = {reg_wdata, cnt_d[7:0]};
      end else if (reg_wr && hit(reg_addr, `ECTM_A_CNTL)) begin
         cnt_d = {cnt_d[15:8], reg_wdata};
      end
      toutn_d = ~tout_d;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control registers, status with write-one-to-clear, set wins
   always_comb begin
      ctl0_d = ctl0_q;
      ctl1_d = ctl1_q;
      rld_d = rld_q;
      mask_d = mask_q;
      stat_d = stat_q;
      if (reg_wr) begin
         if (hit(reg_addr, `ECTM_A_CTL0)) begin
            ctl0_d = reg_wdata;
         end else if (hit(reg_addr, `ECTM_A_CTL1)) begin
            ctl1_d = reg_wdata;
         end else if (hit(reg_addr, `ECTM_A_RLDH)) begin
            rld_d = {reg_wdata, rld_q[7:0]};
         end else if (hit(reg_addr, `ECTM_A_RLDL)) begin
            rld_d = {rld_q[15:8], reg_wdata};
         end else if (hit(reg_addr, `ECTM_A_STAT)) begin
            stat_d = stat_q & ~reg_wdata[1:0];
         end else if (hit(reg_addr, `ECTM_A_MASK)) begin
            mask_d = reg_wdata[1:0];
         end
      end
      // Capture/compare source selection narrows which events interrupt
      if (rld_ev && (mode != ECTM_MODE_CAPCMP || isrc != ECTM_ISRC_CAP)) begin
         stat_d[`ECTM_B_ST_RLD] = 1'b1;
      end
      if (cap_ev && isrc != ECTM_ISRC_RLD) begin
         stat_d[`ECTM_B_ST_CAP] = 1'b1;
      end
      irq_d = |(stat_d & mask_d);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux, data one cycle after the strobe
   always_comb begin
      rdata_d = `ECTM_ZERO8;
      if (reg_rd) begin
         if (hit(reg_addr, `ECTM_A_CTL0)) begin
            rdata_d = ctl0_q;
         end else if (hit(reg_addr, `ECTM_A_CTL1)) begin
            rdata_d = ctl1_q;
         end else if (hit(reg_addr, `ECTM_A_CNTH)) begin
            rdata_d = cnt_q[15:8];
         end else if (hit(reg_addr, `ECTM_A_CNTL)) begin
            rdata_d = cnt_q[7:0];
         end else if (hit(reg_addr, `ECTM_A_RLDH)) begin
            rdata_d = rld_q[15:8];
         end else if (hit(reg_addr, `ECTM_A_RLDL)) begin
            rdata_d = rld_q[7:0];
         end else if (hit(reg_addr, `ECTM_A_CAPH)) begin
            rdata_d = cap_q[15:8];
         end else if (hit(reg_addr, `ECTM_A_CAPL)) begin
            rdata_d = cap_q[7:0];
         end else if (hit(reg_addr, `ECTM_A_STAT)) begin
            rdata_d = {6'h00, stat_q};
         end else if (hit(reg_addr, `ECTM_A_MASK)) begin
            rdata_d = {6'h00, mask_q};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // All state registers
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ctl0_q <= `ECTM_CTL_RST;
         ctl1_q <= `ECTM_CTL_RST;
         cnt_q <= `ECTM_CNT_RST;
         rld_q <= `ECTM_RLD_RST;
         cap_q <= 16'h0000;
         stat_q <= 2'h0;
         mask_q <= 2'h0;
         pre_q <= `ECTM_ZERO8;
         tout_q <= 1'b0;
         toutn_q <= 1'b1;
         irq_q <= 1'b0;
         rdata_q <= `ECTM_ZERO8;
         st_q <= ECTM_ST_IDLE;
      end else begin
         ctl0_q <= ctl0_d;
         ctl1_q <= ctl1_d;
         cnt_q <= cnt_d;
         rld_q <= rld_d;
         cap_q <= cap_d;
         stat_q <= stat_d;
         mask_q <= mask_d;
         pre_q <= pre_d;
         tout_q <= tout_d;
         toutn_q <= toutn_d;
         irq_q <= irq_d;
         rdata_q <= rdata_d;
         st_q <= st_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign timer_out = tout_q;
   assign timer_out_n = toutn_q;
   assign irq = irq_q;
endmodule

// >>> test/ectm_props.sv
`timescale 1ns/1ps
module ectm_props (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic timer_in,
   input wire logic comp_in,
   input wire logic timer_out,
   input wire logic timer_out_n,
   input wire logic irq
);
   logic [7:0] ctl0_q;
   logic [7:0] ctl1_q;
   logic [7:0] mask_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////
   // Shadow copies of control and mask writes
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ctl0_q <= 8'h00;
         ctl1_q <= 8'h00;
         mask_q <= 8'h00;
      end else if (reg_wr) begin
         if (reg_addr == 4'h0) ctl0_q <= reg_wdata;
         if (reg_addr == 4'h1) ctl1_q <= reg_wdata & 8'h83;
         if (reg_addr == 4'h9) mask_q <= reg_wdata;
      end
   end
   ////////////////////////////////////////
   // Output toggle while running
   sequence s_toggle;
      ctl0_q[7] && $past(ctl0_q[7]) && $changed(timer_out);
   endsequence
   property p_rd_idle;
      !reg_rd |=> reg_rdata == 8'h00;
   endproperty
   property p_rd_ctl0;
      reg_rd && reg_addr == 4'h0 |=> (reg_rdata & 8'hF7) == ($past(ctl0_q) & 8'hF7);
   endproperty
   property p_rd_ctl1;
      reg_rd && reg_addr == 4'h1 |=> (reg_rdata & 8'h83) == $past(ctl1_q);
   endproperty
   property p_out_compl;
      timer_out_n == !timer_out;
   endproperty
   property p_out_idle;
      !ctl0_q[7] && $stable(ctl0_q) |-> timer_out == ctl0_q[6];
   endproperty
   property p_tog_oe;
      s_toggle |-> ctl1_q[7];
   endproperty
   property p_tog_irq;
      s_toggle ##0 mask_q[0] |=> irq;
   endproperty
   property p_irq_masked;
      mask_q[1:0] == 2'h0 && $past(mask_q[1:0]) == 2'h0 |-> !irq;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   a_rd_ctl0: assert property (p_rd_ctl0) else $error("control read wrong");
   a_rd_ctl1: assert property (p_rd_ctl1) else $error("control two read wrong");
   a_out_compl: assert property (p_out_compl) else $error("outputs not complementary");
   a_out_idle: assert property (p_out_idle) else $error("idle output level wrong");
   a_tog_oe: assert property (p_tog_oe) else $error("toggle without output enable");
   a_tog_irq: assert property (p_tog_irq) else $error("reload without interrupt");
   a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt seen");
endmodule
bind ectm_top ectm_props i_ectm_props (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .timer_in(timer_in), .comp_in(comp_in),
   .timer_out(timer_out), .timer_out_n(timer_out_n), .irq(irq));

// >>> test/ectm_src.sv
`timescale 1ns/1ps
module ectm_src (
   input wire logic sys_clk,
   input wire logic go,
   input wire logic [7:0] tog,
   input wire logic [2:0] half,
   output logic sig,
   output logic busy
);
   logic [7:0] left_q;
   logic [2:0] cnt_q;
   initial begin
      sig = 1'b0;
      left_q = 8'h00;
      cnt_q = 3'h0;
   end
   assign busy = left_q != 8'h00;
   // Square wave of a set number of toggles; half of two or more clocks
   always @(posedge sys_clk) begin
      if (go) begin
         left_q <= tog;
         cnt_q <= 3'h0;
      end else if (busy) begin
         cnt_q <= cnt_q + 3'h1;
         if (cnt_q == half - 3'h1) begin
            cnt_q <= 3'h0;
            sig <= ~sig;
            left_q <= left_q - 8'h01;
         end
      end
   end
endmodule

// >>> test/ectm_top_tb.sv
`timescale 1ns/1ps
module ectm_top_tb;
   logic sys_clk, sys_rst, reg_wr, reg_rd, timer_in, comp_in, timer_out, timer_out_n, irq;
   logic go, bt, bc, p, m, lv, lt, lc;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d, c0, t, tog_t, tog_c;
   logic [2:0] half;
   logic [15:0] lf, n, s, w;
   logic [17:0] r;
   int fail_count, compares, e;
   ectm_top i_ectm_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .timer_in(timer_in), .comp_in(comp_in), .timer_out(timer_out),
      .timer_out_n(timer_out_n), .irq(irq));
   ectm_src i_ectm_src_t (.sys_clk(sys_clk), .go(go), .tog(tog_t), .half(half),
      .sig(timer_in), .busy(bt));
   ectm_src i_ectm_src_c (.sys_clk(sys_clk), .go(go), .tog(tog_c), .half(half),
      .sig(comp_in), .busy(bc));
   ////////////////////////////////////////
   // Clock and watchdog
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      #200000;
      fail_count++;
      end_sim();
   end
   ////////////////////////////////////////
   // Expectation helpers and bus tasks
   function automatic logic [15:0] nx(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   function automatic logic [17:0] run_exp(input logic [15:0] st, input logic [15:0] rl,
                                           input int ed);
      logic [15:0] c;
      logic any, par;
      c = st;
      any = 1'b0;
      par = 1'b0;
      repeat (ed) begin
         if (c == rl) begin
            c = 16'h0001;
            any = 1'b1;
            par = ~par;
         end else c = c + 16'h0001;
      end
      return {any, par, c};
   endfunction
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] x);
      compares++;
      if (g !== x) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, g, x);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic pulse(input logic [7:0] a, input logic [7:0] b);
      @(posedge sys_clk);
      go <= 1'b1;
      tog_t <= a;
      tog_c <= b;
      @(posedge sys_clk);
      go <= 1'b0;
      // Busy rises on the same edge that takes go
      @(posedge sys_clk);
      for (int j = 0; j < 400 && (bt || bc); j++) @(posedge sys_clk);
      chk({15'h0, bt | bc}, 16'h0000);
      repeat (8) @(posedge sys_clk);
   endtask
   ////////////////////////////////////////
   // Main sequence
   initial begin
      {sys_rst, reg_wr, reg_rd, go} = 4'h8;
      {reg_addr, reg_wdata, tog_t, tog_c, half} = '0;
      {lt, lc} = 2'h0;
      lf = 16'h67E8;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(4'h3);
      chk({8'h00, d}, 16'h0001);
      rd(4'hF);
      chk({8'h00, d}, 16'h0000);
      for (int k = 0; k < 8; k++) begin
         lf = nx(lf);
         {m, p} = k[1:0];
         n = {13'h0, lf[2:0]} + 16'h0003;
         s = (k == 7) ? n : 16'h0001;
         half = 3'h2 + {1'b0, lf[13:12]};
         t = {3'h0, lf[8:4]} + 8'h01;
         wr(4'h0, {1'b0, p, 1'b0, m, 4'h0});
         wr(4'h3, s[7:0]);
         wr(4'h2, s[15:8]);
         wr(4'h5, n[7:0]);
         wr(4'h4, n[15:8]);
         wr(4'h9, {7'h0, lf[14]});
         wr(4'h1, {lf[15], 7'h0});
         wr(4'h0, {1'b1, p, 1'b0, m, 4'h0});
         rd(4'h0);
         chk({8'h00, d}, {8'h00, 1'b1, p, 1'b0, m, 4'h0});
         rd(4'h1);
         chk({8'h00, d}, {8'h00, lf[15], 7'h00});
         lv = m ? lc : lt;
         e = (lv == p) ? (int'(t) + 1) / 2 : int'(t) / 2;
         if (m) pulse({2'h0, lf[9:4]} | 8'h01, t);
         else pulse(t, {2'h0, lf[9:4]} | 8'h01);
         // The idle source always makes an odd number of toggles
         lt = lt ^ (m ? 1'b1 : t[0]);
         lc = lc ^ (m ? t[0] : 1'b1);
         r = run_exp(s, n, e);
         rd(4'h3);
         w[7:0] = d;
         rd(4'h2);
         chk({d, w[7:0]}, r[15:0]);
         rd(4'h8);
         chk({15'h0, d[0]}, {15'h0, r[17]});
         chk({15'h0, irq}, {15'h0, r[17] & lf[14]});
         chk({15'h0, timer_out}, {15'h0, p ^ (lf[15] & r[16])});
         wr(4'h8, 8'h01);
         repeat (2) @(posedge sys_clk);
         chk({15'h0, irq}, 16'h0000);
         $display("test %0d done", k);
      end
      // Capture mode waits for its first edge before counting
      wr(4'h0, 8'h00);
      wr(4'h3, 8'h01);
      wr(4'h5, 8'hFF);
      wr(4'h4, 8'hFF);
      wr(4'h1, 8'h00);
      wr(4'h9, 8'h03);
      wr(4'h0, 8'hA0);
      repeat (20) @(posedge sys_clk);
      rd(4'h3);
      chk({8'h00, d}, 16'h0001);
      pulse(lt ? 8'h02 : 8'h01, 8'h00);
      chk({15'h0, irq}, 16'h0000);
      rd(4'h3);
      c0 = d;
      rd(4'h3);
      chk({8'h00, d - c0}, 16'h0002);
      // Second rising edge captures the count and interrupts
      lt = 1'b1;
      pulse(8'h02, 8'h00);
      rd(4'h8);
      chk({14'h0, d[1:0]}, 16'h0002);
      chk({15'h0, irq}, 16'h0001);
      rd(4'h6);
      chk({8'h00, d}, 16'h0000);
      rd(4'h7);
      chk({15'h0, d > c0}, 16'h0001);
      // Reload-only source hides the capture event
      wr(4'h8, 8'h03);
      wr(4'h1, 8'h02);
      pulse(8'h02, 8'h00);
      rd(4'h8);
      chk({14'h0, d[1:0]}, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      $display("capture test done");
      end_sim();
   end
endmodule
